// ### setpoint_pkg.sv
// constants and encodings for the setpoint output block
package setpoint_pkg;

  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int VALUE_W = 18;
  localparam int HYST_W = 16;
  localparam int DELAY_W = 13;
  localparam int CMP_W = 20;

  // ----------------------------------------
  // documented limits
  // ----------------------------------------
  localparam logic signed [VALUE_W-1:0] SETPOINT_MIN = -18'sd19999;
  localparam logic signed [VALUE_W-1:0] SETPOINT_MAX = 18'sd99999;
  localparam logic [HYST_W-1:0] HYST_MIN = 16'h0001;
  localparam logic [HYST_W-1:0] HYST_MAX = 16'hEA5F;
  localparam logic [DELAY_W-1:0] DELAY_MAX_S = 13'h176F;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [DELAY_W-1:0] DELAY_RST = 13'h0000;
  localparam logic COLOR_RST = 1'b0;

  // ----------------------------------------
  // setpoint action and reset action codes
  // ----------------------------------------
  typedef enum logic [1:0] {
    HIGH_BALANCED_ACTION = 2'h0,
    LOW_BALANCED_ACTION = 2'h1,
    HIGH_UNBALANCED_ACTION = 2'h2,
    low_unbalanced_action = 2'h3
  } action_t;

  typedef enum logic [1:0] {
    AUTO_RESET_MODE = 2'h0,
    latch_immediate_mode = 2'h1,
    latch_delayed_reset_mode = 2'h2
  } reset_mode_t;

  // ----------------------------------------
  // power-up sequencing, one-hot
  // ----------------------------------------
  typedef enum logic [2:0] {
    BOOT_ST = 3'b001,
    FIRST_EVAL_ST = 3'b010,
    RUN_ST = 3'b100
  } boot_t;

endpackage

// ### setpoint_output.sv
// setpoint comparator, delay timers, reset actions and color change
`timescale 1ns/1ps

// How it works
// - high acting, band split around setpoint
// - low acting, band split around setpoint
// - unbalanced band below high, above low
// - signed setpoint -19999 to 99999 counts
// - hysteresis 1..59999 shapes switching thresholds
// - on-delay up to 5999 s, zero immediate; not clamped here, any 13-bit value up to 8191 s is timed
// - off-delay up to 5999 s, zero immediate; not clamped here, any 13-bit value up to 8191 s is timed
// - auto mode clears output at off point
// - auto manual reset clears until recrossed
// - latch modes hold until reset or power
// - immediate latch reset clears at once
// - delayed latch reset waits for off point
// - power-up clears latch when value below setpoint
// - pending delayed reset dropped unless held
// - display reset may also reset output
// - only with display-reset function and input shown
// - standby blocks output until first crossing
// - backlight color toggles on output change
// - disabled setpoint keeps output inactive
module setpoint_output
  import setpoint_pkg::*;
#(
  parameter int DELAY_BITS = DELAY_W
)
(
  // clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // configuration
  input wire logic enable_i,
  input wire logic [1:0] action_i,
  input wire logic [1:0] reset_mode_i,
  input wire logic signed [VALUE_W-1:0] setpoint_i,
  input wire logic [HYST_W-1:0] hysteresis_i,
  input wire logic [DELAY_BITS-1:0] on_delay_i,
  input wire logic [DELAY_BITS-1:0] off_delay_i,
  input wire logic reset_with_display_i,
  input wire logic display_reset_function_i,
  input wire logic input_shown_i,
  input wire logic standby_i,
  input wire logic color_change_i,
  // measurement and timing
  input wire logic signed [VALUE_W-1:0] value_i,
  input wire logic value_update_i,
  input wire logic second_tick_i,
  // reset sources
  input wire logic manual_reset_i,
  input wire logic display_reset_i,
  input wire logic serial_reset_i,
  // state kept over a power cycle
  input wire logic retained_latch_i,
  input wire logic retained_pending_i,
  // status
  output logic output_o,
  output logic color_o,
  output logic pending_reset_o,
  output logic standby_o
);

  // ----------------------------------------
  // thresholds
  // ----------------------------------------
  logic signed [CMP_W-1:0] value_x;
  logic signed [CMP_W-1:0] sp_x;
  logic signed [CMP_W-1:0] half_lo;
  logic signed [CMP_W-1:0] half_hi;
  logic signed [CMP_W-1:0] full_h;
  logic signed [VALUE_W-1:0] sp_c;
  logic [HYST_W-1:0] h_c;
  logic on_hit;
  logic off_hit;

  // clamp keeps out-of-range setup from wrapping the compare
  assign sp_c = (setpoint_i < SETPOINT_MIN) ? SETPOINT_MIN
              : (setpoint_i > SETPOINT_MAX) ? SETPOINT_MAX : setpoint_i;
  assign h_c = (hysteresis_i < HYST_MIN) ? HYST_MIN
             : (hysteresis_i > HYST_MAX) ? HYST_MAX : hysteresis_i;

  always_comb
  begin
    value_x = CMP_W'(value_i);
    sp_x = CMP_W'(sp_c);
    full_h = CMP_W'({1'b0, h_c});
    half_lo = full_h >>> 1;
    half_hi = full_h - half_lo;
    on_hit = 1'b0;
    off_hit = 1'b0;
    unique case (action_t'(action_i))
      HIGH_BALANCED_ACTION:
      begin
        on_hit = value_x > sp_x + half_hi;
        off_hit = value_x < sp_x - half_lo;
      end
      LOW_BALANCED_ACTION:
      begin
        on_hit = value_x < sp_x - half_lo;
        off_hit = value_x > sp_x + half_hi;
      end
      HIGH_UNBALANCED_ACTION:
      begin
        on_hit = value_x > sp_x;
        off_hit = value_x < sp_x - full_h;
      end
      low_unbalanced_action:
      begin
        on_hit = value_x < sp_x;
        off_hit = value_x > sp_x + full_h;
      end
    endcase
  end

  // ----------------------------------------
  // power-up sequencing
  // ----------------------------------------
  boot_t boot_r;
  logic held_at_boot_r;

  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
    begin
      boot_r <= BOOT_ST;
    end
    else
    begin
      unique case (boot_r)
        BOOT_ST: boot_r <= FIRST_EVAL_ST;
        FIRST_EVAL_ST: if (value_update_i) boot_r <= RUN_ST;
        RUN_ST: boot_r <= RUN_ST;
      endcase
    end
  end

  // reset input level caught on the first clock after release
  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
      held_at_boot_r <= 1'b0;
    else if (boot_r == BOOT_ST)
      held_at_boot_r <= manual_reset_i;
  end

  // ----------------------------------------
  // hysteresis state, updated per display update
  // ----------------------------------------
  logic cond_r;

  always_ff @(posedge clock_i)
  begin
    if (!rstn_i || !enable_i)
    begin
      cond_r <= 1'b0;
    end
    else if (value_update_i)
    begin
      if (on_hit)
      begin
        cond_r <= 1'b1;
      end
      else if (off_hit)
      begin
        cond_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // on/off delay filter
  // ----------------------------------------
  logic trig_r;
  logic [DELAY_BITS-1:0] secs_r;
  logic [DELAY_BITS-1:0] delay_sel;
  logic trig_rise;
  logic trig_fall;

  assign delay_sel = cond_r ? on_delay_i : off_delay_i;

  always_ff @(posedge clock_i)
  begin
    if (!rstn_i || !enable_i)
    begin
      trig_r <= 1'b0;
      secs_r <= DELAY_BITS'(DELAY_RST);
    end
    else if (cond_r == trig_r)
    begin
      secs_r <= DELAY_BITS'(DELAY_RST);
    end
    else if (secs_r >= delay_sel)
    begin
      trig_r <= cond_r;
      secs_r <= DELAY_BITS'(DELAY_RST);
    end
    else if (second_tick_i)
    begin
      secs_r <= secs_r + 1'b1;
    end
  end

  // trig_r only changes through the filter, so edges are real crossings
  logic trig_d_r;

  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
    begin
      trig_d_r <= 1'b0;
    end
    else
    begin
      trig_d_r <= trig_r;
    end
  end

  assign trig_rise = trig_r && !trig_d_r;
  assign trig_fall = !trig_r && trig_d_r;

  // ----------------------------------------
  // reset requests
  // ----------------------------------------
  logic disp_rst_ok;
  logic man_rst;
  logic is_latch;
  logic is_delayed;

  assign disp_rst_ok = display_reset_i && reset_with_display_i
                       && display_reset_function_i && input_shown_i;
  assign man_rst = manual_reset_i || disp_rst_ok;
  assign is_latch = reset_mode_i != 2'(AUTO_RESET_MODE);
  assign is_delayed = reset_mode_i == 2'(latch_delayed_reset_mode);

  // ----------------------------------------
  // standby
  // ----------------------------------------
  logic standby_r;

  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
    begin
      standby_r <= 1'b0;
    end
    else if (boot_r == BOOT_ST)
    begin
      standby_r <= standby_i && enable_i;
    end
    else if (standby_r && boot_r == RUN_ST && (!cond_r || !enable_i))
    begin
      standby_r <= 1'b0; // off side seen, next rise is a crossing
    end
  end

  // ----------------------------------------
  // output and delayed-reset memory
  // ----------------------------------------
  logic out_r;
  logic pend_r;
  logic rise_ok;

  assign rise_ok = trig_rise && !standby_r;

  always_ff @(posedge clock_i)
  begin
    if (!rstn_i || !enable_i)
      out_r <= 1'b0; // power cycle clears
    else if (boot_r == FIRST_EVAL_ST)
    begin
      if (value_update_i && is_latch && retained_latch_i)
        out_r <= value_x >= sp_x;
    end
    else if (serial_reset_i && is_latch)
      out_r <= 1'b0;
    else if (rise_ok)
      out_r <= 1'b1;
    else if (!is_latch && (trig_fall || man_rst))
      out_r <= 1'b0;
    else if (is_latch && !is_delayed && man_rst)
      out_r <= 1'b0;
    else if (is_delayed && (pend_r || man_rst) && !trig_r)
      out_r <= 1'b0;
  end

  always_ff @(posedge clock_i)
  begin
    if (!rstn_i || !enable_i || !is_delayed)
      pend_r <= 1'b0;
    else if (boot_r == FIRST_EVAL_ST)
      pend_r <= retained_pending_i && held_at_boot_r;
    else if (serial_reset_i || (out_r && !trig_r && (pend_r || man_rst)))
      pend_r <= 1'b0;
    else if (man_rst && out_r)
      pend_r <= 1'b1;
  end

  // ----------------------------------------
  // backlight color
  // ----------------------------------------
  logic color_r;
  logic out_d_r;

  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
    begin
      color_r <= COLOR_RST;
      out_d_r <= 1'b0;
    end
    else
    begin
      out_d_r <= out_r;
      if (color_change_i && (out_r != out_d_r))
      begin
        color_r <= !color_r;
      end
    end
  end

  assign output_o = out_r;
  assign color_o = color_r;
  assign pending_reset_o = pend_r;
  assign standby_o = standby_r;

endmodule

// ### meter_source.sv
// stand-in for the meter measurement path feeding the setpoint block
`timescale 1ns/1ps
module meter_source
  import setpoint_pkg::*;
#(
  parameter int TICK_CYCLES = 40
)
(
  // clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // bench requests
  input wire logic signed [VALUE_W-1:0] level_i,
  input wire logic send_i,
  // toward the block
  output logic signed [VALUE_W-1:0] value_o = '0,
  output logic update_o = 1'b0,
  output logic tick_o = 1'b0
);
  int count_r = 0;

  // shortened second keeps delay runs brief
  always @(posedge clock_i)
  begin
    count_r <= (!rstn_i || count_r >= TICK_CYCLES - 1) ? 0 : count_r + 1;
    tick_o <= rstn_i && count_r == TICK_CYCLES - 1;
  end

  // display value only changes together with its update pulse
  always @(posedge clock_i)
  begin
    update_o <= send_i;
    if (send_i)
      value_o <= level_i;
  end
endmodule

// ### setpoint_output_chk.sv
// port assertions for the setpoint output block
`timescale 1ns/1ps
module setpoint_output_chk
  import setpoint_pkg::*;
#(
  parameter int DELAY_BITS = DELAY_W
)
(
  // clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // configuration and stimulus
  input wire logic enable_i,
  input wire logic [1:0] action_i,
  input wire logic [1:0] reset_mode_i,
  input wire logic signed [VALUE_W-1:0] setpoint_i,
  input wire logic [HYST_W-1:0] hysteresis_i,
  input wire logic [DELAY_BITS-1:0] on_delay_i,
  input wire logic [DELAY_BITS-1:0] off_delay_i,
  input wire logic color_change_i,
  input wire logic signed [VALUE_W-1:0] value_i,
  input wire logic value_update_i,
  input wire logic manual_reset_i,
  input wire logic display_reset_i,
  input wire logic serial_reset_i,
  // status
  input wire logic output_o,
  input wire logic color_o,
  input wire logic pending_reset_o,
  input wire logic standby_o
);
  logic signed [CMP_W-1:0] hs;
  logic signed [CMP_W-1:0] on_lvl;
  logic signed [CMP_W-1:0] off_lvl;
  logic auto_hi;
  assign hs = {4'h0, hysteresis_i};
  assign on_lvl = CMP_W'(setpoint_i) + ((hs + CMP_W'(1)) >>> 1);
  assign off_lvl = CMP_W'(setpoint_i) - (hs >>> 1);
  // only the auto high-balanced case is timed here, the bench covers the rest
  assign auto_hi = enable_i && action_i == 2'h0 && reset_mode_i == 2'h0 && value_update_i;

  // reference band state: a real turn-on needs the off side seen first
  logic cond_m_r;
  always_ff @(posedge clock_i)
  begin
    if (!rstn_i || !enable_i)
      cond_m_r <= 1'b0;
    else if (action_i != 2'h0)
      cond_m_r <= 1'b1;
    else if (value_update_i && value_i > on_lvl)
      cond_m_r <= 1'b1;
    else if (value_update_i && value_i < off_lvl)
      cond_m_r <= 1'b0;
  end

  default clocking @(posedge clock_i);
  endclocking
  default disable iff (!rstn_i);

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  disabled_off_a: assert property (!enable_i |=> !output_o)
    else $error("output on while setpoint disabled");
  on_resp_a: assert property (auto_hi && !cond_m_r && on_delay_i == '0 && !standby_o
    && value_i > on_lvl |-> ##3 output_o)
    else $error("output late turning on");
  off_resp_a: assert property (auto_hi && off_delay_i == '0 && output_o
    && value_i < off_lvl |-> ##3 !output_o)
    else $error("output late turning off");
  color_toggle_a: assert property (color_change_i && enable_i && $changed(output_o)
    |=> $changed(color_o))
    else $error("color did not follow output");
  color_hold_a: assert property (enable_i && !$changed(output_o) |=> $stable(color_o))
    else $error("color moved without output change");
  serial_latch_a: assert property (serial_reset_i && reset_mode_i != 2'h0 |=> !output_o)
    else $error("serial reset ignored in latch");
  latch_hold_a: assert property (reset_mode_i == 2'h1 && enable_i && output_o
    && !manual_reset_i && !serial_reset_i && !display_reset_i |=> output_o)
    else $error("latched output dropped");
  pending_mode_a: assert property ($rose(pending_reset_o) |-> reset_mode_i == 2'h2)
    else $error("pending reset outside delayed latch");
  reset_zero_a: assert property (disable iff (1'b0) !rstn_i
    |=> !output_o && !color_o && !pending_reset_o && !standby_o)
    else $error("outputs not cleared by reset");

  cover property ($rose(output_o));
  cover property ($rose(pending_reset_o));
  cover property (standby_o ##1 !standby_o);
endmodule

bind setpoint_output setpoint_output_chk #(.DELAY_BITS(DELAY_BITS)) chk (.*);

// ### setpoint_output_bench.sv
// self-checking bench for the setpoint output block
`timescale 1ns/1ps
module setpoint_output_bench;
  import setpoint_pkg::*;
  logic clock_i = 0;
  logic rstn_i = 0;
  logic en = 1, rwd = 0, dfn = 1, shown = 0, stby = 1, ret_l = 0, ret_p = 0;
  logic man = 0, drst = 0, srst = 0, send = 0, cc = 1;
  logic [1:0] act = 0, mode = 0;
  logic [DELAY_W-1:0] ond = 0, offd = 0;
  logic signed [VALUE_W-1:0] lvl = 0, val;
  logic upd, tick, out, col, pend, sb;
  int tbl [4][3] = '{'{106, 95, 94}, '{94, 105, 106}, '{101, 90, 89}, '{99, 110, 111}};
  int bad_count = 0;
  int tests_run = 0;

  always #12.5 clock_i = ~clock_i;

  meter_source src (.clock_i(clock_i), .rstn_i(rstn_i), .level_i(lvl), .send_i(send),
    .value_o(val), .update_o(upd), .tick_o(tick));

  setpoint_output dut (.clock_i(clock_i), .rstn_i(rstn_i), .enable_i(en), .action_i(act),
    .reset_mode_i(mode), .setpoint_i(18'sh0_0064), .hysteresis_i(16'h000A),
    .on_delay_i(ond), .off_delay_i(offd), .reset_with_display_i(rwd),
    .display_reset_function_i(dfn), .input_shown_i(shown), .standby_i(stby),
    .color_change_i(cc), .value_i(val), .value_update_i(upd), .second_tick_i(tick),
    .manual_reset_i(man), .display_reset_i(drst), .serial_reset_i(srst),
    .retained_latch_i(ret_l), .retained_pending_i(ret_p), .output_o(out),
    .color_o(col), .pending_reset_o(pend), .standby_o(sb));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic finish_test;
    if (bad_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  task automatic chk(input logic got, input logic exp);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %b want %b", $time, got, exp);
    end
  endtask

  task automatic boot;
    rstn_i = 0;
    step(5);
    rstn_i = 1;
    step(2);
  endtask

  task automatic put(input int v);
    lvl = VALUE_W'(v);
    send = 1;
    step(1);
    send = 0;
  endtask

  task automatic hit(ref logic s);
    s = 1;
    step(1);
    s = 0;
  endtask

  // bounded wait for the output, then color must match output parity
  task automatic settle(input logic exp);
    int i;
    i = 0;
    while (i < 400 && out !== exp)
    begin
      step(1);
      i++;
    end
    chk(out, exp);
    if (out !== exp)
      finish_test();
    step(2);
    chk(col, exp);
  endtask

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial
  begin
    boot();
    chk(sb, 1);
    put(106);
    step(6);
    chk(out, 0);
    put(94);
    step(3);
    chk(sb, 0);
    stby = 0;
    for (int a = 0; a < 4; a++)
    begin
      act = a[1:0];
      put(tbl[a][0]);
      settle(1);
      put(tbl[a][1]);
      step(6);
      chk(out, 1);
      put(tbl[a][2]);
      settle(0);
    end
    act = 0;
    ond = 2;
    offd = 2;
    put(94);
    put(106);
    step(10);
    chk(out, 0);
    settle(1);
    put(94);
    step(10);
    chk(out, 1);
    settle(0);
    ond = 0;
    offd = 0;
    put(106);
    settle(1);
    hit(man);
    chk(out, 0);
    put(105);
    step(6);
    chk(out, 0);
    put(94);
    put(106);
    settle(1);
    rwd = 1;
    hit(drst);
    step(3);
    chk(out, 1);
    shown = 1;
    hit(drst);
    settle(0);
    mode = 1;
    put(94);
    put(106);
    settle(1);
    put(50);
    step(6);
    chk(out, 1);
    hit(srst);
    chk(out, 0);
    put(106);
    settle(1);
    hit(man);
    chk(out, 0);
    put(107);
    step(6);
    chk(out, 0);
    mode = 2;
    put(94);
    put(106);
    settle(1);
    hit(man);
    step(1);
    chk(pend, 1);
    chk(out, 1);
    put(94);
    settle(0);
    chk(pend, 0);
    ret_l = 1;
    ret_p = 1;
    boot();
    put(100);
    settle(1);
    chk(pend, 0);
    cc = 0;
    en = 0;
    step(3);
    chk(out, 0);
    chk(col, 1);
    en = 1;
    man = 1;
    boot();
    man = 0;
    put(90);
    step(6);
    chk(out, 0);
    chk(pend, 1);
    finish_test();
  end
endmodule
